/* external_memory_bus_control.sv */
// external memory bus controller: apb control register, table read/write bus cycles
// assumes configuration inputs static after reset and pins resolved by port logic outside
`include "ext_bus_cfg.svh"
`default_nettype none
module external_memory_bus_control #(
  parameter int TCY_CLKS = `EBC_TCY_CLKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ext_bus_pkg::bus_cfg_t cfg,
  input wire logic exec_external,
  input wire logic req_valid,
  input wire ext_bus_pkg::bus_req_t req,
  output logic req_ready,
  output logic rsp_done,
  output logic [15:0] rsp_rdata,
  input wire logic [15:0] ad_in,
  output logic [15:0] ad_out,
  output logic [15:0] ad_oe,
  output logic [3:0] upper_addr_out,
  output logic [3:0] upper_addr_oe,
  output logic ale,
  output logic oe_n,
  output logic wrl_n,
  output logic wrh_n,
  output logic ba0,
  output logic ce_n,
  output logic lb_n,
  output logic ub_n,
  output logic [19:0] addr_line_own,
  output logic ctl_own
);
  import ext_bus_pkg::*;

  bus_cfg_t cfg_q;
  logic cfg_loaded;
  logic [7:0] external_bus_control;
  bus_state_t state;
  bus_req_t op;
  logic [1:0] op_wm;
  logic [1:0] op_code;
  logic [15:0] wait_cnt;
  logic [7:0] hold_byte;
  logic req_fire;
  logic bus_needed;
  logic [15:0] data_lanes;
  logic [15:0] wdata16;
  logic apb_access;

  // lines usable by the bus for each address width
  function automatic logic [19:0] width_mask(input addr_width_t aw);
    case (aw)
      AW_20: width_mask = 20'hFFFFF;
      AW_16: width_mask = 20'h0FFFF;
      AW_12: width_mask = 20'h00FFF;
      default: width_mask = 20'h000FF;
    endcase
  endfunction : width_mask

  function automatic logic [15:0] wait_clks(input logic [1:0] code, input logic en);
    logic [15:0] tcys;
    tcys = 16'(`EBC_MAX_WAIT - code);
    wait_clks = en ? 16'(tcys * 16'(TCY_CLKS)) : 16'h0000;
  endfunction : wait_clks

  // 16-bit data presents word address on the lines, byte select on ba0
  function automatic logic [19:0] line_addr(input logic [20:0] a, input logic d16);
    line_addr = d16 ? a[20:1] : a[19:0];
  endfunction : line_addr

  assign req_fire = req_valid && req_ready;
  assign data_lanes = cfg_q.data16 ? 16'hFFFF : 16'h00FF;
  // word write pairs the held first byte below the second byte
  assign wdata16 = (cfg_q.data16 && op_wm[1]) ? {op.wdata, hold_byte}
                                              : {op.wdata, op.wdata};
  assign apb_access = psel && penable;
  assign bus_needed = (cfg_q.mode == MODE_MPU)
                      || !external_bus_control[`EBC_RELEASE_BIT]
                      || (state != ST_IDLE) || req_fire || exec_external;

  // configuration caught after reset release; no register path reaches it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= '0;
      cfg_loaded <= 1'b0;
    end else if (clk_en && !cfg_loaded) begin
      cfg_q <= cfg;
      cfg_loaded <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      external_bus_control <= `EBC_CTRL_RESET;
    end else if (clk_en && apb_access && pready && pwrite && paddr == `EBC_CTRL_OFFSET
                 && cfg_loaded && cfg_q.mode != MODE_SINGLE) begin
      external_bus_control <= pwdata[7:0] & `EBC_CTRL_WMASK;
    end
  end

  // one wait cycle on every access; unmapped addresses answer with pslverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (clk_en) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      if (apb_access && !pready) begin
        pready <= 1'b1;
        case (paddr)
          `EBC_CTRL_OFFSET: prdata <= {24'h000000, external_bus_control};
          `EBC_STATUS_OFFSET: prdata <= {25'h0000000, cfg_q.aw, cfg_q.data16,
                                         cfg_q.mode, ctl_own, state != ST_IDLE};
          default: begin
            prdata <= 32'h00000000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // pin ownership toward the port muxes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_line_own <= 20'h00000;
      ctl_own <= 1'b0;
    end else if (clk_en) begin
      if (!cfg_loaded || cfg_q.mode == MODE_SINGLE) begin
        addr_line_own <= 20'h00000;
        ctl_own <= 1'b0;
      end else begin
        // unused high lines never follow the release bit
        addr_line_own <= bus_needed ? width_mask(cfg_q.aw) : 20'h00000;
        ctl_own <= bus_needed;
      end
    end
  end

  // bus cycle sequencer and its pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      op <= '0;
      op_wm <= 2'b00;
      op_code <= 2'b00;
      wait_cnt <= 16'h0000;
      hold_byte <= 8'h00;
      req_ready <= 1'b0;
      rsp_done <= 1'b0;
      rsp_rdata <= 16'h0000;
      ad_out <= 16'h0000;
      ad_oe <= 16'h0000;
      upper_addr_out <= 4'h0;
      upper_addr_oe <= 4'h0;
      ale <= 1'b0;
      oe_n <= 1'b1;
      wrl_n <= 1'b1;
      wrh_n <= 1'b1;
      ba0 <= 1'b0;
      ce_n <= 1'b1;
      lb_n <= 1'b1;
      ub_n <= 1'b1;
    end else if (clk_en) begin
      rsp_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          req_ready <= cfg_loaded && cfg_q.mode != MODE_SINGLE;
          if (req_fire) begin
            req_ready <= 1'b0;
            op <= req;
            op_wm <= external_bus_control[`EBC_WM_LSB +: 2];
            op_code <= external_bus_control[`EBC_WAIT_LSB +: 2];
            wait_cnt <= wait_clks(external_bus_control[`EBC_WAIT_LSB +: 2],
                                  cfg_q.wait_en);
            {upper_addr_out, ad_out} <= line_addr(req.addr, cfg_q.data16);
            {upper_addr_oe, ad_oe} <= width_mask(cfg_q.aw);
            ba0 <= req.addr[0];
            ale <= 1'b1;
            ce_n <= 1'b0;
            state <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          ale <= 1'b0;
          state <= ST_DATA;
          if (!op.write) begin
            // data lanes turn round; address-only lines keep the address
            ad_oe <= ad_oe & ~data_lanes;
            oe_n <= 1'b0;
            if (cfg_q.data16) begin
              ub_n <= 1'b0;
              lb_n <= 1'b0;
            end
          end else begin
            ad_out <= (ad_out & ~data_lanes) | (wdata16 & data_lanes);
            if (!cfg_q.data16) begin
              wrl_n <= 1'b0;
            end else begin
              case (op_wm)
                2'b00: begin
                  if (op.addr[0]) begin
                    wrh_n <= 1'b0;
                  end else begin
                    wrl_n <= 1'b0;
                  end
                end
                2'b01: begin
                  wrh_n <= 1'b0;
                  ub_n <= !op.addr[0];
                  lb_n <= op.addr[0];
                end
                default: begin
                  if (op.addr[0]) begin
                    wrh_n <= 1'b0;
                    ub_n <= 1'b0;
                    lb_n <= 1'b0;
                  end else begin
                    // first byte only held; lanes float, no strobe
                    hold_byte <= op.wdata;
                    ad_oe <= ad_oe & ~data_lanes;
                  end
                end
              endcase
            end
          end
        end
        ST_DATA: begin
          // memory must be done by the last wait cycle
          if (wait_cnt != 16'h0000) begin
            wait_cnt <= wait_cnt - 16'h0001;
          end else begin
            if (!op.write) begin
              rsp_rdata <= ad_in & data_lanes;
            end
            rsp_done <= 1'b1;
            ad_oe <= 16'h0000;
            upper_addr_oe <= 4'h0;
            oe_n <= 1'b1;
            wrl_n <= 1'b1;
            wrh_n <= 1'b1;
            ub_n <= 1'b1;
            lb_n <= 1'b1;
            ce_n <= 1'b1;
            ba0 <= 1'b0;
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // helper: data phase length of the running operation
  logic [15:0] data_clks;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_clks <= 16'h0000;
    end else if (clk_en) begin
      if (state == ST_ADDR) begin
        data_clks <= 16'h0000;
      end else if (state == ST_DATA) begin
        data_clks <= data_clks + 16'h0001;
      end
    end
  end

  property p_unimpl_zero;
    @(posedge pclk) disable iff (!presetn)
      (pready && !pslverr && $past(paddr) == `EBC_CTRL_OFFSET)
      |-> (prdata[6] == 1'b0 && prdata[3:2] == 2'b00);
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("reserved bits read nonzero");

  property p_single_chip;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && cfg_loaded && cfg_q.mode == MODE_SINGLE)
      |=> (addr_line_own == 20'h00000 && !ctl_own && !req_ready);
  endproperty
  a_single_chip: assert property (p_single_chip) else $error("bus active in single-chip");

  property p_mpu_on;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && cfg_loaded && cfg_q.mode == MODE_MPU) |=> ctl_own;
  endproperty
  a_mpu_on: assert property (p_mpu_on) else $error("bus off in external program mode");

  property p_release_zero;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && cfg_loaded && cfg_q.mode != MODE_SINGLE
       && !external_bus_control[`EBC_RELEASE_BIT])
      |=> (ctl_own && addr_line_own == width_mask(cfg_q.aw));
  endproperty
  a_release_zero: assert property (p_release_zero) else $error("bus not held");

  property p_release_one;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && cfg_loaded && cfg_q.mode != MODE_MPU
       && external_bus_control[`EBC_RELEASE_BIT] && state == ST_IDLE
       && !req_fire && !exec_external) |=> (!ctl_own && addr_line_own == 20'h00000);
  endproperty
  a_release_one: assert property (p_release_one) else $error("bus not released");

  property p_idle_pins;
    @(posedge pclk) disable iff (!presetn)
      (state == ST_IDLE || state == ST_DONE) |-> (ad_oe == 16'h0000 && oe_n && wrh_n
       && wrl_n && ub_n && lb_n && ce_n && !ale && !ba0);
  endproperty
  a_idle_pins: assert property (p_idle_pins) else $error("idle pin levels wrong");

  property p_addr16_upper;
    @(posedge pclk) disable iff (!presetn)
      (cfg_loaded && cfg_q.aw == AW_16) |-> (upper_addr_oe == 4'h0 && !addr_line_own[16]);
  endproperty
  a_addr16_upper: assert property (p_addr16_upper) else $error("upper lines used");

  property p_byte_write;
    @(posedge pclk) disable iff (!presetn)
      (state == ST_DATA && op.write && cfg_q.data16 && op_wm == 2'b00)
      |-> (wrh_n != wrl_n && wrh_n == !op.addr[0]);
  endproperty
  a_byte_write: assert property (p_byte_write) else $error("byte write strobes wrong");

  property p_byte_select;
    @(posedge pclk) disable iff (!presetn)
      (state == ST_DATA && op.write && cfg_q.data16 && op_wm == 2'b01)
      |-> (!wrh_n && wrl_n && ub_n == !op.addr[0] && lb_n == op.addr[0]);
  endproperty
  a_byte_select: assert property (p_byte_select) else $error("byte select strobes wrong");

  property p_word_even;
    @(posedge pclk) disable iff (!presetn)
      (state == ST_DATA && op.write && cfg_q.data16 && op_wm[1] && !op.addr[0])
      |-> (wrh_n && wrl_n && ad_oe == 16'h0000);
  endproperty
  a_word_even: assert property (p_word_even) else $error("even word write drove bus");

  property p_wait_len;
    @(posedge pclk) disable iff (!presetn)
      $rose(rsp_done) |-> (data_clks == 16'h0001
        + (cfg_q.wait_en ? 16'(16'(2'h3 - op_code) * 16'(TCY_CLKS)) : 16'h0000));
  endproperty
  a_wait_len: assert property (p_wait_len) else $error("wait length wrong");

  property p_narrow;
    @(posedge pclk) disable iff (!presetn)
      (cfg_loaded && cfg_q.aw == AW_8 && !cfg_q.data16)
      |-> (ad_oe[15:8] == 8'h00 && upper_addr_oe == 4'h0);
  endproperty
  a_narrow: assert property (p_narrow) else $error("8/8 mode used upper lines");
endmodule : external_memory_bus_control
`default_nettype wire

/* ext_bus_cfg.svh */
// constants for the external memory bus controller: offsets, fields, resets, timing
// assumes a 32-bit apb slave and an instruction cycle of a whole number of pclk periods
`ifndef EXT_BUS_CFG_SVH
`define EXT_BUS_CFG_SVH
`define EBC_CTRL_OFFSET 12'h000
`define EBC_STATUS_OFFSET 12'h004
`define EBC_RELEASE_BIT 7
`define EBC_WAIT_LSB 4
`define EBC_WM_LSB 0
`define EBC_CTRL_RESET 8'h00
`define EBC_CTRL_WMASK 8'hB3
`define EBC_MAX_WAIT 2'h3
`define EBC_TCY_CLKS 4
`endif

/* ext_bus_pkg.sv */
// types for the external memory bus controller
// assumes ext_bus_cfg.svh supplies the numeric constants
`default_nettype none
package ext_bus_pkg;
  typedef enum logic [1:0] {
    AW_8 = 2'b00, AW_12 = 2'b01, AW_16 = 2'b10, AW_20 = 2'b11
  } addr_width_t;
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00, MODE_EXT_MCU = 2'b01, MODE_BOOT = 2'b10, MODE_MPU = 2'b11
  } mem_mode_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_ADDR = 2'b01, ST_DATA = 2'b10, ST_DONE = 2'b11
  } bus_state_t;
  typedef struct packed {
    logic data16;
    addr_width_t aw;
    logic wait_en;
    mem_mode_t mode;
  } bus_cfg_t;
  typedef struct packed {
    logic write;
    logic [20:0] addr;
    logic [7:0] wdata;
  } bus_req_t;
endpackage : ext_bus_pkg
`default_nettype wire

/* ext_mem_model.sv */
// external memory partner: latches the address on ale, answers reads, records writes
// assumes active-low strobes and per-line enables from the bus controller
`default_nettype none
module ext_mem_model (
  input wire logic pclk,
  input wire logic slow,
  input wire logic [15:0] ad_out,
  input wire logic [15:0] ad_oe,
  input wire logic [3:0] upper_addr_out,
  input wire logic ale,
  input wire logic ba0,
  input wire logic oe_n,
  input wire logic wrl_n,
  input wire logic wrh_n,
  input wire logic ub_n,
  input wire logic lb_n,
  output logic [15:0] ad_in,
  output logic [19:0] lat_addr,
  output logic lat_ba,
  output logic [15:0] wr_data,
  output logic [3:0] wr_stb,
  output logic [7:0] wr_count
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] last = 16'h0000;
  logic [15:0] src;
  logic [2:0] oe_cnt = 3'h0;
  logic wr_prev = 1'b0;
  logic [7:0] n_wr = 8'h00;
  logic wr_now;
  assign wr_now = !wrh_n || !wrl_n;
  assign wr_count = n_wr;
  // released lines show the inverse of the last level, never a stale match
  always_comb begin
    src = ~last;
    if (!oe_n && (!slow || oe_cnt >= 3'h2)) begin
      src = {~lat_addr[7:0], lat_addr[7:0]};
    end
    ad_in = (ad_oe & ad_out) | (~ad_oe & src);
  end
  always_ff @(posedge pclk) begin
    last <= ad_in;
    oe_cnt <= oe_n ? 3'h0 : (oe_cnt == 3'h7 ? oe_cnt : oe_cnt + 3'h1);
    if (ale) begin
      lat_addr <= {upper_addr_out, ad_out};
      lat_ba <= ba0;
    end
    wr_prev <= wr_now;
    if (wr_now && !wr_prev) begin
      wr_data <= ad_in;
      wr_stb <= {~wrh_n, ~wrl_n, ~ub_n, ~lb_n};
      n_wr <= n_wr + 8'h01;
    end
  end
endmodule : ext_mem_model
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the external memory bus controller
// assumes the memory partner model and an instruction cycle of two pclk periods
`include "ext_bus_cfg.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ext_bus_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, req_valid, req_ready;
  logic exec_external, rsp_done, ale, oe_n, wrl_n, wrh_n, ba0, ce_n, lb_n, ub_n, slow;
  logic ctl_own;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] rsp_rdata, ad_in, ad_out, ad_oe, wr_data, oe_seen;
  logic [3:0] upper_addr_out, upper_addr_oe, wr_stb;
  logic [19:0] addr_line_own, lat_addr, own_seen;
  logic [7:0] wr_count;
  logic lat_ba;
  bus_cfg_t cfg;
  bus_req_t req;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  external_memory_bus_control #(.TCY_CLKS(2)) DUT (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cfg(cfg), .exec_external(exec_external), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp_done(rsp_done), .rsp_rdata(rsp_rdata),
    .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe), .upper_addr_out(upper_addr_out),
    .upper_addr_oe(upper_addr_oe), .ale(ale), .oe_n(oe_n), .wrl_n(wrl_n), .wrh_n(wrh_n),
    .ba0(ba0), .ce_n(ce_n), .lb_n(lb_n), .ub_n(ub_n), .addr_line_own(addr_line_own),
    .ctl_own(ctl_own));
  ext_mem_model mem (
    .pclk(pclk), .slow(slow), .ad_out(ad_out), .ad_oe(ad_oe),
    .upper_addr_out(upper_addr_out), .ale(ale), .ba0(ba0), .oe_n(oe_n), .wrl_n(wrl_n),
    .wrh_n(wrh_n), .ub_n(ub_n), .lb_n(lb_n), .ad_in(ad_in), .lat_addr(lat_addr),
    .lat_ba(lat_ba), .wr_data(wr_data), .wr_stb(wr_stb), .wr_count(wr_count));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  // ceiling well above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 8000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready, read data and error are taken at the rising edge that shows pready high
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, a, d, rd, e);
  endtask : wr_reg
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 32'h00000000, rd, e);
    check(rd & m, exp);
  endtask : rd_chk
  task automatic restart(input logic d16, input addr_width_t aw, input mem_mode_t m,
                         input logic we);
    @(posedge pclk);
    presetn <= 1'b0;
    cfg <= '{data16: d16, aw: aw, wait_en: we, mode: m};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask : restart
  task automatic settle();
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask : settle
  task automatic top_op(input logic wr, input logic [20:0] a, input logic [7:0] d,
                        input int exp_n);
    int n;
    n = 0;
    @(posedge pclk);
    req_valid <= 1'b1;
    req <= '{write: wr, addr: a, wdata: d};
    do @(posedge pclk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    own_seen = '0;
    oe_seen = '0;
    do begin
      @(negedge pclk);
      n++;
      own_seen |= addr_line_own;
      oe_seen |= ad_oe;
    end while (rsp_done !== 1'b1 && n < 100);
    check(32'(n), 32'(exp_n));
    check({ad_oe, ale, ba0, oe_n, wrl_n, wrh_n, ce_n, lb_n, ub_n}, {16'h0, 2'b00, 6'h3F});
  endtask : top_op
  task automatic t_regs();
    logic [31:0] rd;
    logic e;
    restart(1'b1, AW_20, MODE_EXT_MCU, 1'b1);
    rd_chk(`EBC_CTRL_OFFSET, 32'hFFFFFFFF, 32'h00000000);
    wr_reg(`EBC_CTRL_OFFSET, 32'hFFFFFFFF);
    rd_chk(`EBC_CTRL_OFFSET, 32'hFFFFFFFF, 32'h000000B3);
    wr_reg(`EBC_STATUS_OFFSET, 32'h00000000);
    rd_chk(`EBC_STATUS_OFFSET, 32'h0000007C, 32'h00000074);
    apb(1'b0, 12'h008, 32'h00000000, rd, e);
    check(e, 1'b1);
  endtask : t_regs
  task automatic t_waits();
    logic [20:0] a;
    restart(1'b1, AW_20, MODE_EXT_MCU, 1'b1);
    for (int code = 0; code < 4; code++) begin
      a = 21'h1A2B3C + 21'(code);
      slow <= (code == 0);
      wr_reg(`EBC_CTRL_OFFSET, 32'(code) << 4);
      top_op(1'b0, a, 8'h00, 3 + (3 - code) * 2);
      check(rsp_rdata, {~a[8:1], a[8:1]});
      check({lat_addr, lat_ba}, {a[20:1], a[0]});
    end
    slow <= 1'b0;
    restart(1'b1, AW_20, MODE_EXT_MCU, 1'b0);
    top_op(1'b0, 21'h000010, 8'h00, 3);
  endtask : t_waits
  task automatic t_writes();
    logic [3:0] e;
    logic [3:0] m4;
    logic [7:0] c0;
    restart(1'b1, AW_20, MODE_EXT_MCU, 1'b0);
    for (int m = 0; m < 2; m++) begin
      for (int odd = 0; odd < 2; odd++) begin
        wr_reg(`EBC_CTRL_OFFSET, 32'(m));
        top_op(1'b1, 21'h000100 + 21'(odd), 8'h5A, 3);
        e = {m == 1 || odd == 1, m == 0 && odd == 0, m == 1 && odd == 1, m == 1 && odd == 0};
        m4 = (m == 0) ? 4'hC : 4'hF;
        check(wr_data, 16'h5A5A);
        check(wr_stb & m4, e & m4);
      end
    end
    for (int m = 2; m < 4; m++) begin
      wr_reg(`EBC_CTRL_OFFSET, 32'(m));
      c0 = wr_count;
      top_op(1'b1, 21'h000200, 8'h11, 3);
      check(wr_count, c0);
      top_op(1'b1, 21'h000201, 8'h22, 3);
      check({wr_data, wr_stb}, {16'h2211, 4'b1011});
    end
  endtask : t_writes
  task automatic t_own();
    restart(1'b1, AW_16, MODE_EXT_MCU, 1'b0);
    settle();
    check({addr_line_own, upper_addr_oe}, {20'h0FFFF, 4'h0});
    wr_reg(`EBC_CTRL_OFFSET, 32'h00000080);
    settle();
    check({ctl_own, addr_line_own}, 21'h000000);
    @(posedge pclk);
    exec_external <= 1'b1;
    settle();
    check(addr_line_own, 20'h0FFFF);
    @(posedge pclk);
    exec_external <= 1'b0;
    top_op(1'b0, 21'h000042, 8'h00, 3);
    check(own_seen, 20'h0FFFF);
    restart(1'b1, AW_20, MODE_MPU, 1'b0);
    wr_reg(`EBC_CTRL_OFFSET, 32'h00000080);
    settle();
    check({ctl_own, addr_line_own}, {1'b1, 20'hFFFFF});
    restart(1'b0, AW_8, MODE_EXT_MCU, 1'b0);
    settle();
    check(addr_line_own, 20'h000FF);
    top_op(1'b0, 21'h0000A5, 8'h00, 3);
    check(rsp_rdata, 16'h00A5);
    top_op(1'b1, 21'h0000A7, 8'h3C, 3);
    check({wr_data[7:0], wr_stb[3:2]}, {8'h3C, 2'b01});
    restart(1'b1, AW_12, MODE_BOOT, 1'b0);
    wr_reg(`EBC_CTRL_OFFSET, 32'h00000080);
    settle();
    check({ctl_own, addr_line_own}, 21'h000000);
    top_op(1'b1, 21'h000301, 8'h66, 3);
    check(own_seen, 20'h00FFF);
    check(oe_seen, 16'h0FFF);
    restart(1'b1, AW_20, MODE_SINGLE, 1'b0);
    wr_reg(`EBC_CTRL_OFFSET, 32'h00000080);
    rd_chk(`EBC_CTRL_OFFSET, 32'hFFFFFFFF, 32'h00000000);
    check({req_ready, addr_line_own}, 21'h000000);
  endtask : t_own
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    exec_external = 1'b0;
    req_valid = 1'b0;
    req = '0;
    cfg = '0;
    slow = 1'b0;
    t_regs();
    t_waits();
    t_writes();
    t_own();
    close_out();
  end
endmodule : tb_top
`default_nettype wire
